// ===== hw/daaic_pkg.sv
// package: register map, field layout, timing constants and carriers
package daaic_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned RING_HOLD_S = 5;
  localparam int unsigned WDOG_S = 4;
  // least time, whole seconds, so no rounding needed
  localparam int unsigned RING_HOLD_CYC = RING_HOLD_S * CLK_HZ;
  localparam int unsigned WDOG_CYC = WDOG_S * CLK_HZ;

  localparam int ADDR_W = 8;
  localparam int IDX_W = 6;
  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_CTRL = 6'h02;
  localparam logic [IDX_W-1:0] IDX_MASK = 6'h03;
  localparam logic [IDX_W-1:0] IDX_FLAGS = 6'h04;
  localparam logic [IDX_W-1:0] IDX_LINE_CTRL = 6'h05;
  localparam logic [IDX_W-1:0] IDX_PWR = 6'h06;
  localparam logic [IDX_W-1:0] IDX_LINE_STAT = 6'h11;

  // flag and mask layout
  localparam int B_RING = 7;
  localparam int B_ROV = 6;
  localparam int B_FRAME = 5;
  localparam int B_BILL = 4;
  localparam int B_DROP = 3;
  localparam int B_LCS = 2;
  localparam int B_POL = 0;
  localparam logic [7:0] FLAG_IMPL = 8'hFD;

  // control register
  localparam int B_GIE = 7;
  localparam int B_WDEN = 4;
  localparam int B_BOTH = 2;
  localparam int B_FULLW = 1;
  localparam int B_PINEN = 0;
  localparam logic [7:0] CTRL_IMPL = 8'h97;

  // line control register
  localparam int B_RNEG = 6;
  localparam int B_RPOS = 5;
  localparam int B_ONHOOK_MONITOR_ENABLE = 3;
  localparam int B_RPRES = 2;
  localparam int B_HOOK = 0;
  // power register
  localparam int B_PDL = 4;
  // line status register
  localparam int B_ROVS = 0;
  localparam int B_DODS = 1;
  localparam int B_OPDS = 2;

  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [4:0] LCS_MAX = 5'h1F;
  localparam int LVS_SIGN = 7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic ring_pos;
    logic ring_neg;
    logic rx_overload;
    logic frame_lock;
    logic billing_tone;
    logic supply_dropout_detect;
    logic overcurrent_status;
    logic [4:0] loop_current_level;
    logic [7:0] line_voltage_value;
  } daaic_line_in_t;

  typedef struct packed {
    logic offhook;
    logic onhook_monitor_enable;
    logic line_side_powerdown;
  } daaic_line_out_t;
endpackage

// ===== hw/daaic_timer.sv
// file: one-shot down counter with registered expiry pulse
`timescale 1ns/100ps
module daaic_timer #(
  parameter int W = 28,
  parameter int unsigned COUNT = 200_000_000
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic restart,
  input wire logic stop,
  output logic expired
);
  localparam logic [W-1:0] LOAD = W'(COUNT - 1);
  localparam logic [W-1:0] ZERO = '0;
  logic [W-1:0] cnt_r;
  logic run_r;

  generate
    if (COUNT < 1 || COUNT > (64'd1 << W)) begin : g_bad
      $error("daaic_timer: COUNT does not fit W");
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= ZERO;
      run_r <= 1'b0;
    end else if (restart) begin
      cnt_r <= LOAD;
      run_r <= 1'b1;
    end else if (stop || (run_r && cnt_r == ZERO)) begin
      run_r <= 1'b0;
    end else if (run_r) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      expired <= 1'b0;
    end else begin
      expired <= run_r && cnt_r == ZERO && !restart && !stop;
    end
  end
endmodule

// ===== hw/daaic_top.sv
// file: line-interface interrupt flags, hook control, axi4-lite slave
`timescale 1ns/100ps
module daaic_top #(
  parameter bit POL_SUPPORT = 1'b1,
  parameter int TMR_W = 28,
  parameter int unsigned RING_HOLD_CYC = daaic_pkg::RING_HOLD_CYC,
  parameter int unsigned WDOG_CYC = daaic_pkg::WDOG_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [daaic_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [daaic_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire daaic_pkg::daaic_line_in_t line_in,
  input wire logic hook_pin,
  output daaic_pkg::daaic_line_out_t line_out,
  output logic irq
);
  typedef logic [daaic_pkg::IDX_W-1:0] daaic_idx_t;

  generate
    if (TMR_W < 8 || TMR_W > 32) begin : g_bad_w
      $error("daaic_top: TMR_W out of range");
    end
  endgenerate

  function automatic daaic_idx_t reg_index(input logic [daaic_pkg::ADDR_W-1:0] a);
    reg_index = a[daaic_pkg::ADDR_W-1:2];
  endfunction

  function automatic logic is_mapped(input daaic_idx_t i);
    is_mapped = (i == daaic_pkg::IDX_CTRL) || (i == daaic_pkg::IDX_MASK) ||
                (i == daaic_pkg::IDX_FLAGS) || (i == daaic_pkg::IDX_LINE_CTRL) ||
                (i == daaic_pkg::IDX_PWR) || (i == daaic_pkg::IDX_LINE_STAT);
  endfunction

  // write channel holding registers; address and data may come in either order
  logic aw_full_r;
  logic w_full_r;
  logic [daaic_pkg::ADDR_W-1:0] awaddr_r;
  logic [7:0] wdata_r;
  logic wlane_r;
  logic do_write;
  daaic_idx_t widx;
  logic wr_en;

  assign do_write = aw_full_r && w_full_r && !s_axi_bvalid;
  assign widx = reg_index(awaddr_r);
  assign wr_en = do_write && wlane_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      awaddr_r <= '0;
      s_axi_awready <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end else if (do_write) begin
        aw_full_r <= 1'b0;
      end
      s_axi_awready <= !aw_full_r && !(s_axi_awvalid && s_axi_awready);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_r <= 1'b0;
      wdata_r <= daaic_pkg::RST_BYTE;
      wlane_r <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_r <= 1'b1;
        wdata_r <= s_axi_wdata[7:0];
        // registers are one byte wide; only lane 0 reaches them
        wlane_r <= s_axi_wstrb[0];
      end else if (do_write) begin
        w_full_r <= 1'b0;
      end
      s_axi_wready <= !w_full_r && !(s_axi_wvalid && s_axi_wready);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= daaic_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= is_mapped(widx) ? daaic_pkg::RESP_OKAY : daaic_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // software-owned state
  logic [7:0] ctrl_r;
  logic [7:0] mask_r;
  logic onhook_monitor_enable_r;
  logic hook_r;
  logic pdl_r;
  logic wdog_en_r;
  logic wdog_en_set;
  logic wdog_expired;

  assign wdog_en_set = wr_en && widx == daaic_pkg::IDX_CTRL && wdata_r[daaic_pkg::B_WDEN];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= daaic_pkg::RST_BYTE;
      mask_r <= daaic_pkg::RST_BYTE;
      onhook_monitor_enable_r <= 1'b0;
      pdl_r <= 1'b0;
    end else if (wr_en) begin
      if (widx == daaic_pkg::IDX_CTRL) begin
        ctrl_r <= wdata_r & daaic_pkg::CTRL_IMPL;
      end
      if (widx == daaic_pkg::IDX_MASK) begin
        mask_r <= wdata_r & daaic_pkg::FLAG_IMPL;
      end
      if (widx == daaic_pkg::IDX_LINE_CTRL) begin
        onhook_monitor_enable_r <= wdata_r[daaic_pkg::B_ONHOOK_MONITOR_ENABLE];
      end
      if (widx == daaic_pkg::IDX_PWR) begin
        pdl_r <= wdata_r[daaic_pkg::B_PDL];
      end
    end
  end

  // watchdog enable sticks until reset once set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wdog_en_r <= 1'b0;
    end else if (wdog_en_set) begin
      wdog_en_r <= 1'b1;
    end
  end

  // a software write of one wins over a watchdog expiry in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hook_r <= 1'b0;
    end else if (wr_en && widx == daaic_pkg::IDX_LINE_CTRL) begin
      hook_r <= wdata_r[daaic_pkg::B_HOOK];
    end else if (wdog_expired) begin
      hook_r <= 1'b0;
    end
  end

  daaic_timer #(
    .W(TMR_W),
    .COUNT(WDOG_CYC)
  ) u_wdog (
    .aclk(aclk),
    .aresetn(aresetn),
    // the enabling write starts the count, else it would stay unarmed until the next write
    .restart((wdog_en_r && do_write) || wdog_en_set),
    .stop(!wdog_en_r),
    .expired(wdog_expired)
  );

  // line event detection
  logic ring_any;
  logic ring_prev_r;
  logic sign_prev_r;
  logic sign_seen_r;
  logic [7:0] ev_set;
  logic [7:0] ev_clr;
  logic [7:0] flags_r;

  assign ring_any = line_in.ring_pos || line_in.ring_neg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ring_prev_r <= 1'b0;
      sign_prev_r <= 1'b0;
      sign_seen_r <= 1'b0;
    end else begin
      ring_prev_r <= ring_any;
      sign_prev_r <= line_in.line_voltage_value[daaic_pkg::LVS_SIGN];
      // first sample after reset only primes the comparison
      sign_seen_r <= 1'b1;
    end
  end

  always_comb begin
    ev_set = '0;
    // burst start always; burst end only in two-edge mode
    ev_set[daaic_pkg::B_RING] = (ring_any && !ring_prev_r) ||
                                (ctrl_r[daaic_pkg::B_BOTH] && !ring_any && ring_prev_r);
    ev_set[daaic_pkg::B_ROV] = line_in.rx_overload;
    ev_set[daaic_pkg::B_FRAME] = !line_in.frame_lock;
    ev_set[daaic_pkg::B_BILL] = line_in.billing_tone;
    ev_set[daaic_pkg::B_DROP] = line_in.supply_dropout_detect;
    ev_set[daaic_pkg::B_LCS] = line_in.loop_current_level == daaic_pkg::LCS_MAX;
    ev_set[daaic_pkg::B_POL] = POL_SUPPORT && sign_seen_r &&
        (line_in.line_voltage_value[daaic_pkg::LVS_SIGN] != sign_prev_r);
  end

  // only a written zero clears; a written one is ignored
  assign ev_clr = (wr_en && widx == daaic_pkg::IDX_FLAGS) ? ~wdata_r : '0;

  // set beats clear so an event in the clearing cycle survives
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_r <= daaic_pkg::RST_BYTE;
    end else begin
      flags_r <= ((flags_r & ~ev_clr) | ev_set) & daaic_pkg::FLAG_IMPL;
    end
  end

  // ring present, held by the 5 s timer
  logic ring_qual;
  logic ring_present_r;
  logic ring_expired;
  logic offhook_now;

  assign ring_qual = line_in.ring_pos || (ctrl_r[daaic_pkg::B_FULLW] && line_in.ring_neg);
  assign offhook_now = hook_r || (ctrl_r[daaic_pkg::B_PINEN] && hook_pin);

  daaic_timer #(
    .W(TMR_W),
    .COUNT(RING_HOLD_CYC)
  ) u_ring (
    .aclk(aclk),
    .aresetn(aresetn),
    .restart(ring_qual && !offhook_now),
    .stop(offhook_now),
    .expired(ring_expired)
  );

  // off-hook clears at once; timer counts from the last qualifying ring
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ring_present_r <= 1'b0;
    end else if (offhook_now) begin
      ring_present_r <= 1'b0;
    end else if (ring_qual) begin
      ring_present_r <= 1'b1;
    end else if (ring_expired) begin
      ring_present_r <= 1'b0;
    end
  end

  // line-side outputs and interrupt, all registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_out <= '0;
      irq <= 1'b0;
    end else begin
      line_out.offhook <= offhook_now;
      line_out.onhook_monitor_enable <= onhook_monitor_enable_r;
      line_out.line_side_powerdown <= pdl_r;
      irq <= ctrl_r[daaic_pkg::B_GIE] && |(flags_r & mask_r);
    end
  end

  // read channel
  logic [7:0] rd_byte;
  daaic_idx_t ridx;

  assign ridx = reg_index(s_axi_araddr);

  always_comb begin
    rd_byte = '0;
    unique case (ridx)
      daaic_pkg::IDX_CTRL: begin
        rd_byte = ctrl_r;
        rd_byte[daaic_pkg::B_WDEN] = wdog_en_r;
      end
      daaic_pkg::IDX_MASK: begin
        rd_byte = mask_r;
      end
      daaic_pkg::IDX_FLAGS: begin
        rd_byte = flags_r;
      end
      daaic_pkg::IDX_LINE_CTRL: begin
        rd_byte[daaic_pkg::B_RNEG] = line_in.ring_neg;
        rd_byte[daaic_pkg::B_RPOS] = line_in.ring_pos;
        rd_byte[daaic_pkg::B_ONHOOK_MONITOR_ENABLE] = onhook_monitor_enable_r;
        rd_byte[daaic_pkg::B_RPRES] = ring_present_r;
        rd_byte[daaic_pkg::B_HOOK] = hook_r;
      end
      daaic_pkg::IDX_PWR: begin
        rd_byte[daaic_pkg::B_PDL] = pdl_r;
      end
      daaic_pkg::IDX_LINE_STAT: begin
        // mirror shares the flag flop, so a clear through the flags register clears both
        rd_byte[daaic_pkg::B_ROVS] = flags_r[daaic_pkg::B_ROV];
        rd_byte[daaic_pkg::B_DODS] = line_in.supply_dropout_detect;
        rd_byte[daaic_pkg::B_OPDS] = line_in.overcurrent_status;
      end
      default: begin
        rd_byte = '0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= daaic_pkg::RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h00_0000, rd_byte};
        s_axi_rresp <= is_mapped(ridx) ? daaic_pkg::RESP_OKAY : daaic_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
    end
  end
endmodule

// ===== verif/daaic_props.sv
// checker: bus answers, hook output and interrupt relations at the top ports
`timescale 1ns/100ps
module daaic_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic hook_pin,
  input wire daaic_pkg::daaic_line_out_t line_out,
  input wire logic irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // flags only drop on a written zero, so irq falls only after a write
  AST_IRQ_STICKY: assert property (
    $fell(irq) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("irq fell with no write");
  AST_MODE_BY_WRITE: assert property (
    $changed({line_out.onhook_monitor_enable, line_out.line_side_powerdown})
    |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("mode output moved with no write");
  AST_HOOK_RISE: assert property (
    $rose(line_out.offhook) |-> $past(hook_pin) || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("offhook rose with no cause");
  AST_HOOK_FALL: assert property (
    $fell(line_out.offhook) |-> !$past(hook_pin) || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("offhook fell while pin held");
  AST_RD_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == '0)
    else $error("upper read bits not zero");
  AST_ERR_ZERO: assert property (
    s_axi_rvalid && s_axi_rresp == daaic_pkg::RESP_SLVERR |-> s_axi_rdata == '0)
    else $error("error read carries data");
  AST_WR_ANSWER: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read answer late");
  AST_ONE_WRITE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during answer");
  AST_ONE_READ: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during answer");
  cover property ($fell(irq));
  cover property ($rose(line_out.offhook));
  cover property (s_axi_rvalid && s_axi_rresp == daaic_pkg::RESP_SLVERR);
endmodule

bind daaic_top daaic_props i_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .hook_pin, .line_out, .irq);

// ===== verif/daaic_line_model.sv
// line-side device stand-in: event requests become registered line levels
`timescale 1ns/100ps
module daaic_line_model (
  input wire logic aclk,
  input wire logic [7:0] ev,
  input wire logic [7:0] noise,
  output daaic_pkg::daaic_line_in_t line_in
);
  // ev follows the flag layout; bit 1 is the negative ring half
  always_ff @(posedge aclk) begin
    line_in.ring_pos <= ev[7];
    line_in.ring_neg <= ev[1];
    line_in.rx_overload <= ev[6];
    line_in.frame_lock <= !ev[5];
    line_in.billing_tone <= ev[4];
    line_in.supply_dropout_detect <= ev[3];
    line_in.overcurrent_status <= ev[2] & noise[7];
    // idle noise stays below saturation so it never sets the flag itself
    line_in.loop_current_level <= ev[2] ? daaic_pkg::LCS_MAX : {1'b0, noise[3:0]};
    line_in.line_voltage_value <= {ev[0], noise[6:0]};
  end
endmodule

// ===== verif/daaic_interrupt_and_hook_control_tb.sv
// testbench: register bus, line events, ring status, hook and watchdog
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module daaic_interrupt_and_hook_control_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic hook_pin = 1'b0;
  logic [3:0] wstrb = 4'hF;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, ev = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, seed = 32'h99c8_bdd8;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [1:0] exp_b;
  logic [33:0] exp_r;
  daaic_pkg::daaic_line_in_t line_in;
  daaic_pkg::daaic_line_out_t line_out;
  int mismatches = 0, checks = 0;
  logic [1:0] wq[$];
  logic [33:0] rq[$];
  localparam logic [5:0] REGS [6] = '{daaic_pkg::IDX_CTRL, daaic_pkg::IDX_MASK,
    daaic_pkg::IDX_FLAGS, daaic_pkg::IDX_LINE_CTRL, daaic_pkg::IDX_PWR, daaic_pkg::IDX_LINE_STAT};

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  always #10 aclk = ~aclk;
  always @(posedge aclk) seed <= lfsr(seed);

  daaic_top #(.TMR_W(8), .RING_HOLD_CYC(50), .WDOG_CYC(40)) i_dut (.aclk, .aresetn,
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .line_in, .hook_pin, .line_out, .irq);
  daaic_line_model i_line (.aclk, .ev, .noise(seed[7:0]), .line_in);

  // answers are taken off the queues in the order they were asked for
  always @(posedge aclk) begin
    if (bvalid && bready) begin
      exp_b = wq.pop_front();
      `CHK("bresp", exp_b, bresp)
    end
    if (rvalid && rready) begin
      exp_r = rq.pop_front();
      `CHK("read", exp_r, {rresp, rdata})
    end
  end

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic bound(input int n);
    if (n >= 60) begin
      mismatches++;
      $display("bus wait ran out");
      wrap_up();
    end
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d,
                    input logic [1:0] er = daaic_pkg::RESP_OKAY);
    int n;
    n = 0;
    wq.push_back(er);
    awaddr <= {idx, 2'b00};
    wdata <= 32'(d);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      // bready stays up after the answer so back-to-back calls never set it twice at once
      if (wready) wvalid <= 1'b0;
    end while (n < 60 && !(bvalid && bready));
    bound(n);
  endtask

  task automatic rd(input logic [5:0] idx, input logic [7:0] d,
                    input logic [1:0] er = daaic_pkg::RESP_OKAY);
    int n;
    n = 0;
    rq.push_back({er, 32'(d)});
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (n < 60 && !(rvalid && rready));
    bound(n);
  endtask

  initial begin
    tick(6);
    aresetn <= 1'b1;
    tick(1);
    foreach (REGS[k]) rd(REGS[k], 8'h00);
    rd(6'h3F, 8'h00, daaic_pkg::RESP_SLVERR);
    wr(6'h3F, 8'hFF, daaic_pkg::RESP_SLVERR);
    $display("test reset done");
    wr(daaic_pkg::IDX_CTRL, 8'h80);
    for (int m = 0; m < 2; m++) begin
      wr(daaic_pkg::IDX_MASK, m ? 8'hFD : 8'h00);
      for (int i = 7; i >= 0; i--) if (daaic_pkg::FLAG_IMPL[i]) begin
        ev[i] <= 1'b1;
        tick(3);
        ev[i] <= 1'b0;
        tick(4);
        `CHK("irq set", 1'(m), irq)
        rd(daaic_pkg::IDX_FLAGS, 8'(1 << i));
        rd(daaic_pkg::IDX_LINE_STAT, {7'h00, i == daaic_pkg::B_ROV});
        wr(daaic_pkg::IDX_FLAGS, 8'hFF);
        rd(daaic_pkg::IDX_FLAGS, 8'(1 << i));
        wr(daaic_pkg::IDX_FLAGS, 8'h00);
        tick(2);
        rd(daaic_pkg::IDX_FLAGS, 8'h00);
        rd(daaic_pkg::IDX_LINE_STAT, 8'h00);
        `CHK("irq clear", 1'b0, irq)
      end
    end
    $display("test events done");
    wr(daaic_pkg::IDX_CTRL, 8'h84);
    ev[7] <= 1'b1;
    tick(3);
    // cleared mid-burst, so the burst end must set it again
    wr(daaic_pkg::IDX_FLAGS, 8'h00);
    ev[7] <= 1'b0;
    tick(4);
    rd(daaic_pkg::IDX_FLAGS, 8'h80);
    wr(daaic_pkg::IDX_FLAGS, 8'h00);
    $display("test burst end done");
    tick(60);
    wr(daaic_pkg::IDX_CTRL, 8'h00);
    ev[1] <= 1'b1;
    tick(3);
    rd(daaic_pkg::IDX_LINE_CTRL, 8'h40);
    ev[7] <= 1'b1;
    tick(3);
    rd(daaic_pkg::IDX_LINE_CTRL, 8'h64);
    ev <= 8'h00;
    tick(3);
    rd(daaic_pkg::IDX_LINE_CTRL, 8'h04);
    tick(60);
    rd(daaic_pkg::IDX_LINE_CTRL, 8'h00);
    wr(daaic_pkg::IDX_CTRL, 8'h02);
    ev[1] <= 1'b1;
    tick(3);
    ev[1] <= 1'b0;
    tick(3);
    rd(daaic_pkg::IDX_LINE_CTRL, 8'h04);
    wr(daaic_pkg::IDX_LINE_CTRL, 8'hFF);
    tick(2);
    rd(daaic_pkg::IDX_LINE_CTRL, 8'h09);
    `CHK("offhook", 1'b1, line_out.offhook)
    `CHK("monitor", 1'b1, line_out.onhook_monitor_enable)
    $display("test ring status done");
    // no writes while waiting, reads would not hold the watchdog off anyway
    wr(daaic_pkg::IDX_CTRL, 8'h10);
    tick(55);
    `CHK("watchdog", 1'b0, line_out.offhook)
    rd(daaic_pkg::IDX_LINE_CTRL, 8'h08);
    hook_pin <= 1'b1;
    tick(3);
    `CHK("pin off", 1'b0, line_out.offhook)
    wr(daaic_pkg::IDX_CTRL, 8'h11);
    tick(2);
    `CHK("pin on", 1'b1, line_out.offhook)
    hook_pin <= 1'b0;
    tick(3);
    `CHK("pin low", 1'b0, line_out.offhook)
    $display("test hook done");
    wr(daaic_pkg::IDX_PWR, 8'h10);
    tick(2);
    `CHK("powerdown", 1'b1, line_out.line_side_powerdown)
    wr(daaic_pkg::IDX_PWR, 8'h00);
    wr(daaic_pkg::IDX_FLAGS, 8'h00);
    rd(daaic_pkg::IDX_PWR, 8'h00);
    tick(3);
    // a write with lane 0 off is answered but changes no register; it still restarts the watchdog count
    wstrb <= 4'h0;
    wr(daaic_pkg::IDX_PWR, 8'h10);
    rd(daaic_pkg::IDX_PWR, 8'h00);
    wstrb <= 4'hF;
    `CHK("no lane", 1'b0, line_out.line_side_powerdown)
    $display("test power done");
    wrap_up();
  end
endmodule
